// File: hw/pfr_access_window.v
// staging register window for indirect access to one port's filter rule table
// assumes a synchronous byte register port; the port number is decoded outside
`timescale 1ns/1ps
`default_nettype none
`include "pfr_acl_regs.vh"
module pfr_access_window #(
    parameter ENTRIES = `PFR_ENTRIES,
    parameter IDX_W   = `PFR_IDX_W
) (
    // clock and reset
    input  wire                      core_clk,
    input  wire                      arst_n,
    // register port
    input  wire [`PFR_ADDR_W-1:0]    reg_addr,
    input  wire                      reg_wr,
    input  wire [7:0]                reg_wdata,
    input  wire                      reg_rd,
    output reg  [7:0]                reg_rdata_r,
    output reg                       reg_rvalid_r,
    // transfer status
    output reg                       xfer_busy_r,
    output reg                       xfer_done_r
);
    localparam NB       = `PFR_STAGE_NUM;
    localparam ST_IDLE  = 3'b001;
    localparam ST_RUN   = 3'b010;
    localparam ST_FIN   = 3'b100;

    reg  [2:0]          state_r;
    reg  [2:0]          state_nxt;
    reg  [8*NB-1:0]     stage_r;
    reg  [7:0]          sel_high_r;
    reg  [7:0]          sel_low_r;
    reg  [IDX_W-1:0]    idx_r;
    reg                 dir_wr_r;
    reg                 rd_done_r;
    reg                 wr_done_r;
    reg  [IDX_W-1:0]    xfer_idx_r;
    reg                 xfer_wr_r;
    reg  [NB-1:0]       xfer_mask_r;
    wire [8*NB-1:0]     tbl_rdata;
    wire                start;
    wire [15:0]         sel_next;
    wire [NB-1:0]       mask_next;
    wire                tbl_wr;
    wire                tbl_rd;

    // a start is only taken when idle; a second trigger while busy is dropped
    assign start    = reg_wr && reg_addr == `PFR_OFS_SEL_LOW && state_r == ST_IDLE;
    // select bits run opposite to staging order: bit k of {high,low} picks byte 15-k
    assign sel_next = {sel_high_r, reg_wdata};

    genvar b;
    generate
        for (b = 0; b < NB; b = b + 1) begin : g_mask
            assign mask_next[b] = sel_next[`PFR_SEL_TOP - (b + `PFR_STAGE_FIRST)];
        end
    endgenerate

    assign tbl_wr = state_r == ST_RUN && xfer_wr_r;
    assign tbl_rd = state_r == ST_RUN && !xfer_wr_r;

    pfr_rule_table #(
        .ENTRIES (ENTRIES),
        .IDX_W   (IDX_W),
        .NBYTES  (NB)
    ) u_table (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .idx      (xfer_idx_r),
        .wr_en    (tbl_wr),
        .wr_mask  (xfer_mask_r),
        .wr_data  (stage_r),
        .rd_en    (tbl_rd),
        .rd_data  (tbl_rdata)
    );

    // transfer sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_FIN;
            end
            ST_FIN: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= ST_IDLE;
            xfer_idx_r  <= {IDX_W{1'b0}};
            xfer_wr_r   <= 1'b0;
            xfer_mask_r <= {NB{1'b0}};
            xfer_busy_r <= 1'b0;
            xfer_done_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            xfer_done_r <= state_r == ST_FIN;
            xfer_busy_r <= state_nxt != ST_IDLE;
            if (start) begin
                // entry and direction come from the control register as set beforehand
                xfer_idx_r  <= idx_r;
                xfer_wr_r   <= dir_wr_r;
                xfer_mask_r <= mask_next;
            end
        end
    end

    // completion flags: only the started direction's flag clears on start, both set when the sequencer finishes
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_done_r <= 1'b1;
            wr_done_r <= 1'b1;
        end else if (start) begin
            rd_done_r <= dir_wr_r ? rd_done_r : 1'b0;
            wr_done_r <= dir_wr_r ? 1'b0 : wr_done_r;
        end else if (state_r == ST_FIN) begin
            rd_done_r <= 1'b1;
            wr_done_r <= 1'b1;
        end
    end

    // select and control registers; index and direction are frozen while busy
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_high_r <= `PFR_BYTE_RESET;
            sel_low_r  <= `PFR_BYTE_RESET;
            idx_r      <= {IDX_W{1'b0}};
            dir_wr_r   <= 1'b0;
        end else if (reg_wr && state_r == ST_IDLE) begin
            case (reg_addr)
                `PFR_OFS_SEL_HIGH: begin
                    sel_high_r <= reg_wdata;
                end
                `PFR_OFS_SEL_LOW: begin
                    sel_low_r <= reg_wdata;
                end
                `PFR_OFS_ACC_CTRL: begin
                    idx_r    <= reg_wdata[`PFR_CTRL_IDX_HI:`PFR_CTRL_IDX_LO];
                    dir_wr_r <= reg_wdata[`PFR_CTRL_DIR];
                end
                default: begin
                    sel_high_r <= sel_high_r;
                end
            endcase
        end
    end

    // staging bytes: software writes, or the table loads selected bytes after a read.
    // software writes during a transfer are dropped so the entry sees a stable image
    generate
        for (b = 0; b < NB; b = b + 1) begin : g_stage
            always @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage_r[8*b +: 8] <= `PFR_BYTE_RESET;
                end else if (state_r == ST_FIN && !xfer_wr_r && xfer_mask_r[b]) begin
                    stage_r[8*b +: 8] <= tbl_rdata[8*b +: 8];
                end else if (reg_wr && state_r == ST_IDLE &&
                             reg_addr == `PFR_OFS_MAC3 + b) begin
                    stage_r[8*b +: 8] <= reg_wdata;
                end
            end
        end
    endgenerate

    // byte position of a staging offset inside the packed stage vector
    function [7:0] stage_byte;
        input [8*NB-1:0]         vec;
        input [`PFR_ADDR_W-1:0]  ofs;
        reg   [`PFR_ADDR_W-1:0]  rel;
        begin
            rel        = ofs - `PFR_OFS_MAC3;
            stage_byte = vec[8*rel[3:0] +: 8];
        end
    endfunction

    // read port: one cycle after the strobe; unmapped offsets read as zero.
    // byte A carries mode 7:6, priority 5:3, remark enable 2, remark[2:1] in 1:0;
    // byte B carries remark[0] in 7 and map mode 6:5; byte D carries the port map
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r  <= `PFR_BYTE_RESET;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `PFR_OFS_MAC3, `PFR_OFS_MAC2, `PFR_OFS_MAC1, `PFR_OFS_MAC0: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_ETYPE_HI, `PFR_OFS_ETYPE_LO: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_PRIO_ACT: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_REMARK_MAP: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_RSVD_C: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_FWD_MAP: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_RULESET_HI, `PFR_OFS_RULESET_LO: begin
                        reg_rdata_r <= stage_byte(stage_r, reg_addr);
                    end
                    `PFR_OFS_SEL_HIGH: begin
                        reg_rdata_r <= sel_high_r;
                    end
                    `PFR_OFS_SEL_LOW: begin
                        reg_rdata_r <= sel_low_r;
                    end
                    `PFR_OFS_ACC_CTRL: begin
                        reg_rdata_r <= {1'b0, wr_done_r, rd_done_r, dir_wr_r, idx_r};
                    end
                    default: begin
                        reg_rdata_r <= `PFR_BYTE_RESET;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/pfr_acl_regs.vh
// constants of the packet filter rule staging window: offsets, fields, resets
// assumes a byte-wide register port whose address is the low 12 bits of 0xN6xx
`ifndef PFR_RULE_WINDOW_REGS_VH
`define PFR_RULE_WINDOW_REGS_VH

`define PFR_ADDR_W          12
`define PFR_OFS_MAC3        12'h604
`define PFR_OFS_MAC2        12'h605
`define PFR_OFS_MAC1        12'h606
`define PFR_OFS_MAC0        12'h607
`define PFR_OFS_ETYPE_HI    12'h608
`define PFR_OFS_ETYPE_LO    12'h609
`define PFR_OFS_PRIO_ACT    12'h60A
`define PFR_OFS_REMARK_MAP  12'h60B
`define PFR_OFS_RSVD_C      12'h60C
`define PFR_OFS_FWD_MAP     12'h60D
`define PFR_OFS_RULESET_HI  12'h60E
`define PFR_OFS_RULESET_LO  12'h60F
`define PFR_OFS_SEL_HIGH    12'h610
`define PFR_OFS_SEL_LOW     12'h611
`define PFR_OFS_ACC_CTRL    12'h612

`define PFR_STAGE_FIRST     4
`define PFR_STAGE_LAST      15
`define PFR_STAGE_NUM       12
`define PFR_SEL_TOP         15
`define PFR_BYTE_RESET      8'h00

`define PFR_CTRL_WR_DONE    6
`define PFR_CTRL_RD_DONE    5
`define PFR_CTRL_DIR        4
`define PFR_CTRL_IDX_HI     3
`define PFR_CTRL_IDX_LO     0
`define PFR_IDX_W           4
`define PFR_ENTRIES         16

`define PFR_PRIO_MODE_HI    7
`define PFR_PRIO_MODE_LO    6
`define PFR_PRIO_HI         5
`define PFR_PRIO_LO         3
`define PFR_REMARK_EN_BIT   2
`define PFR_RMK_HI_HI       1
`define PFR_RMK_HI_LO       0
`define PFR_RMK_LSB_BIT     7
`define PFR_MAP_MODE_HI     6
`define PFR_MAP_MODE_LO     5
`define PFR_FWD_HI          6
`define PFR_FWD_LO          0

`endif

// File: hw/pfr_rule_table.v
// byte-maskable storage of the packet filter rule entries
// assumes the caller holds index, mask and data stable during the access cycle
`timescale 1ns/1ps
`default_nettype none
module pfr_rule_table #(
    parameter ENTRIES = 16,
    parameter IDX_W   = 4,
    parameter NBYTES  = 12
) (
    // clock and reset
    input  wire                  core_clk,
    input  wire                  arst_n,
    // access port
    input  wire [IDX_W-1:0]      idx,
    input  wire                  wr_en,
    input  wire [NBYTES-1:0]     wr_mask,
    input  wire [8*NBYTES-1:0]   wr_data,
    input  wire                  rd_en,
    output reg  [8*NBYTES-1:0]   rd_data
);
    reg [8*NBYTES-1:0] entry_r [0:ENTRIES-1];

    genvar e;
    genvar b;
    generate
        for (e = 0; e < ENTRIES; e = e + 1) begin : g_entry
            for (b = 0; b < NBYTES; b = b + 1) begin : g_byte
                always @(posedge core_clk or negedge arst_n) begin
                    if (!arst_n) begin
                        entry_r[e][8*b +: 8] <= 8'h00;
                    end else if (wr_en && wr_mask[b] && idx == e) begin
                        entry_r[e][8*b +: 8] <= wr_data[8*b +: 8];
                    end
                end
            end
        end
    endgenerate

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= {8*NBYTES{1'b0}};
        end else if (rd_en) begin
            rd_data <= entry_r[idx];
        end
    end
endmodule
`default_nettype wire

// File: verif/pfr_window_monitor.sv
// assertions on the ports of the filter rule staging window
// assumes it is bound to pfr_access_window, one clock domain, async low reset
`timescale 1ns/1ps
`default_nettype none
module pfr_window_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_r,
    input wire logic        reg_rvalid_r,
    // transfer status
    input wire logic        xfer_busy_r,
    input wire logic        xfer_done_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire trig = reg_wr && reg_addr == 12'h611;
    wire unmapped = reg_addr < 12'h604 || reg_addr > 12'h612;
    property p_start; trig && !xfer_busy_r |=> xfer_busy_r [*2] ##1 (!xfer_busy_r && xfer_done_r); endproperty
    a_start: assert property (p_start) else $error("transfer did not run two cycles");
    property p_cause; $rose(xfer_busy_r) |-> $past(trig); endproperty
    a_cause: assert property (p_cause) else $error("transfer started without trigger");
    property p_done_pulse; xfer_done_r |=> !xfer_done_r; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_done_after; xfer_done_r |-> $past(xfer_busy_r) && !xfer_busy_r; endproperty
    a_done_after: assert property (p_done_after) else $error("done without busy");
    property p_answer; reg_rd |=> reg_rvalid_r; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_rvalid_cause; reg_rvalid_r |-> $past(reg_rd); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("rvalid without read");
    property p_unmapped; reg_rd && unmapped |=> reg_rdata_r == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold; !reg_rvalid_r |-> $stable(reg_rdata_r); endproperty
    a_hold: assert property (p_hold) else $error("read data changed without read");
    property p_readback;
        !xfer_busy_r && reg_wr && reg_addr == 12'h60D ##2 reg_rd && !reg_wr && reg_addr == 12'h60D
            |=> reg_rdata_r == $past(reg_wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("forward map readback wrong");
endmodule
bind pfr_access_window pfr_window_monitor pfr_window_monitor_i (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .xfer_busy_r(xfer_busy_r),
    .xfer_done_r(xfer_done_r));
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the filter rule staging window
// assumes bus inputs change at the falling edge, outputs sampled there too
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    wire  [7:0]  reg_rdata_r;
    wire         reg_rvalid_r;
    wire         xfer_busy_r;
    wire         xfer_done_r;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          i;
    always #2.5 core_clk = ~core_clk;
    pfr_access_window pfr_access_window_i (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .xfer_busy_r(xfer_busy_r), .xfer_done_r(xfer_done_r));
    // distinct non-zero pattern per staging byte so misrouted bytes show up
    function automatic logic [7:0] pat(input int n);
        return 8'h35 * n[7:0] + 8'h0B;
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check("rvalid", 8'h01, {7'h00, reg_rvalid_r});
        check($sformatf("reg %h", a), exp, reg_rdata_r);
    endtask
    task automatic fill(input logic [7:0] v);
        for (int n = 4; n < 16; n++) wr(12'h600 + n[11:0], v);
    endtask
    // status is read while busy: the started direction must show incomplete
    task automatic xfer(input logic [7:0] ctrl, input logic [7:0] sh, input logic [7:0] sl);
        int k;
        wr(12'h612, ctrl);
        wr(12'h610, sh);
        wr(12'h611, sl);
        rd(12'h612, ctrl | (ctrl[4] ? 8'h20 : 8'h40));
        for (k = 0; k < 8 && xfer_done_r !== 1'b1; k++) @(negedge core_clk);
        check("done", 8'h01, {7'h00, xfer_done_r});
        rd(12'h612, ctrl | 8'h60);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        for (i = 4; i < 18; i++) rd(12'h600 + i[11:0], 8'h00);
        rd(12'h612, 8'h60);
        rd(12'h600, 8'h00);
        rd(12'h613, 8'h00);
        $display("test reset_values done");
        for (i = 4; i < 16; i++) begin
            wr(12'h600 + i[11:0], pat(i));
            rd(12'h600 + i[11:0], pat(i));
        end
        $display("test staging_readback done");
        xfer(8'h13, 8'h0F, 8'hFF);
        fill(8'h00);
        xfer(8'h03, 8'h05, 8'h81);
        for (i = 4; i < 16; i++) rd(12'h600 + i[11:0], (i == 5 || i == 7 || i == 8 || i == 15) ? pat(i) : 8'h00);
        $display("test partial_read done");
        fill(8'hEE);
        xfer(8'h13, 8'h00, 8'h40);
        fill(8'h00);
        xfer(8'h03, 8'h0F, 8'hFF);
        for (i = 4; i < 16; i++) rd(12'h600 + i[11:0], (i == 9) ? 8'hEE : pat(i));
        xfer(8'h04, 8'h0F, 8'hFF);
        for (i = 4; i < 16; i++) rd(12'h600 + i[11:0], 8'h00);
        $display("test partial_write done");
        final_report();
    end
endmodule
`default_nettype wire
